/* File: verilog/ipc_irq_regs.sv */
// posted-flag, soft-post and enable-mask registers with request to the processor
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module ipc_irq_regs
   import ipc_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic srst_i,
   // register port
   input wire ipc_bus_req_t reg_req_i,
   output logic [7:0] reg_rdata_o,
   // source events, one-cycle pulses from logic on this clock
   input wire logic [7:0] hw_evt_b_i,
   input wire logic [7:0] hw_evt_c_i,
   // first posted-flag register lives outside; gated here by its mask
   input wire logic [7:0] posted_flags_a_i,
   output logic [7:0] pending_a_o,
   // processor side
   input wire logic global_irq_enable_i,
   input wire logic take_i,
   output ipc_irq_req_t irq_req_o,
   output logic irq_o
);

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   logic wr_flags_b;
   logic wr_flags_c;
   logic wr_soft;
   logic wr_mask_a;
   logic wr_mask_b;
   logic wr_mask_c;
   logic wr_evt_stat;
   logic wr_evt_mask;

   always_comb begin
      wr_flags_b = 1'b0;
      wr_flags_c = 1'b0;
      wr_soft = 1'b0;
      wr_mask_a = 1'b0;
      wr_mask_b = 1'b0;
      wr_mask_c = 1'b0;
      wr_evt_stat = 1'b0;
      wr_evt_mask = 1'b0;
      if (reg_req_i.wr) begin
         if (reg_req_i.addr == IPC_OFS_FLAGS_B) begin
            wr_flags_b = 1'b1;
         end else if (reg_req_i.addr == IPC_OFS_FLAGS_C) begin
            wr_flags_c = 1'b1;
         end else if (reg_req_i.addr == IPC_OFS_SOFT_CTRL) begin
            wr_soft = 1'b1;
         end else if (reg_req_i.addr == IPC_OFS_MASK_C) begin
            wr_mask_c = 1'b1;
         end else if (reg_req_i.addr == IPC_OFS_MASK_A) begin
            wr_mask_a = 1'b1;
         end else if (reg_req_i.addr == IPC_OFS_MASK_B) begin
            wr_mask_b = 1'b1;
         end else if (reg_req_i.addr == IPC_OFS_EVT_STAT) begin
            wr_evt_stat = 1'b1;
         end else if (reg_req_i.addr == IPC_OFS_EVT_MASK) begin
            wr_evt_mask = 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // soft-post control, holding only the soft-post enable bit
   // ----------------------------------------------------------------
   logic [7:0] soft_ctrl_r;
   logic soft_post_enable;

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         soft_ctrl_r <= IPC_RST_VAL;
      end else if (wr_soft) begin
         soft_ctrl_r <= reg_req_i.wdata & IPC_VALID_SOFT; // [R11]
      end
   end

   assign soft_post_enable = soft_ctrl_r[IPC_SOFT_EN_BIT]; // [R11]

   // ----------------------------------------------------------------
   // enable mask registers a, b and c
   // ----------------------------------------------------------------
   logic [7:0] mask_a_r;
   logic [7:0] mask_b_r;
   logic [7:0] mask_c_r;
   logic [7:0] mask_b_nxt;
   logic [7:0] mask_c_nxt;

   // next values let the request flops see the mask that is about to stand
   always_comb begin
      mask_b_nxt = mask_b_r;
      mask_c_nxt = mask_c_r;
      if (wr_mask_b) begin
         mask_b_nxt = reg_req_i.wdata & IPC_VALID_B; // [R13]
      end
      if (wr_mask_c) begin
         mask_c_nxt = reg_req_i.wdata & IPC_VALID_C; // [R12]
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         mask_a_r <= IPC_RST_VAL;
      end else if (wr_mask_a) begin
         mask_a_r <= reg_req_i.wdata & IPC_VALID_A; // [R13]
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         mask_b_r <= IPC_RST_VAL;
         mask_c_r <= IPC_RST_VAL;
      end else begin
         mask_b_r <= mask_b_nxt;
         mask_c_r <= mask_c_nxt;
      end
   end

   // ----------------------------------------------------------------
   // take: clear the flag of the request the processor accepted
   // ----------------------------------------------------------------
   logic take_ok;
   logic [15:0] take_clr;
   logic [4:0] take_idx;

   assign take_ok = take_i & irq_req_o.valid;
   assign take_idx = irq_req_o.prio - IPC_PRIO_BASE;

   always_comb begin
      take_clr = 16'h0000;
      if (take_ok) begin
         take_clr[take_idx[3:0]] = 1'b1; // [R14]
      end
   end

   // ----------------------------------------------------------------
   // posted-flag registers b and c
   // ----------------------------------------------------------------
   logic [7:0] flags_b;
   logic [7:0] flags_c;
   logic [7:0] flags_b_nxt;
   logic [7:0] flags_c_nxt;

   // bit layout follows the field positions of the package
   ipc_flag_bank #(
      .VALID(IPC_VALID_B)
   ) u_flags_b (
      .sys_clk_i(sys_clk_i),
      .srst_i(srst_i),
      .hw_set_i(hw_evt_b_i),
      .wr_i(wr_flags_b),
      .wdata_i(reg_req_i.wdata),
      .soft_en_i(soft_post_enable),
      .take_clr_i(take_clr[7:0]),
      .flags_o(flags_b),
      .flags_nxt_o(flags_b_nxt)
   ); // [R1]

   ipc_flag_bank #(
      .VALID(IPC_VALID_C)
   ) u_flags_c (
      .sys_clk_i(sys_clk_i),
      .srst_i(srst_i),
      .hw_set_i(hw_evt_c_i),
      .wr_i(wr_flags_c),
      .wdata_i(reg_req_i.wdata),
      .soft_en_i(soft_post_enable),
      .take_clr_i(take_clr[15:8]),
      .flags_o(flags_c),
      .flags_nxt_o(flags_c_nxt)
   ); // [R2]

   // ----------------------------------------------------------------
   // pending requests and priority encoder
   // ----------------------------------------------------------------
   logic [15:0] pending_nxt;
   logic enc_found;
   logic [3:0] enc_index;

   // bitwise and: each mask bit gates its own source only
   assign pending_nxt = {flags_c_nxt & mask_c_nxt, flags_b_nxt & mask_b_nxt}; // [R8] [R10]
   assign pending_a_o = posted_flags_a_i & mask_a_r; // [R8] [R10]

   ipc_prio_enc u_enc (
      .pending_i(pending_nxt),
      .found_o(enc_found),
      .index_o(enc_index)
   );

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         irq_req_o <= '0;
      end else begin
         irq_req_o.valid <= enc_found & global_irq_enable_i; // [R15]
         irq_req_o.prio <= IPC_PRIO_BASE + {1'b0, enc_index};
      end
   end

   // ----------------------------------------------------------------
   // block event status, w1c, and interrupt
   // ----------------------------------------------------------------
   logic [3:0] evt_stat_r;
   logic [3:0] evt_mask_r;
   logic [3:0] evt_set;
   logic [3:0] evt_clr;

   always_comb begin
      evt_set = 4'h0;
      evt_set[IPC_EV_SW_POST] = (wr_flags_b | wr_flags_c) & soft_post_enable
                                & (|reg_req_i.wdata);
      evt_set[IPC_EV_SW_CLEAR] = (wr_flags_b | wr_flags_c) & ~soft_post_enable
                                 & ~(&reg_req_i.wdata);
      evt_set[IPC_EV_MASKED_POST] = |({hw_evt_c_i & IPC_VALID_C & ~mask_c_r,
                                       hw_evt_b_i & IPC_VALID_B & ~mask_b_r}); // [R9]
      evt_set[IPC_EV_TAKEN] = take_ok;
      evt_clr = 4'h0;
      if (wr_evt_stat) begin
         evt_clr = reg_req_i.wdata[3:0];
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         evt_stat_r <= IPC_RST_VAL[3:0];
      end else begin
         // set wins over a same-cycle write of one
         evt_stat_r <= evt_set | (evt_stat_r & ~evt_clr);
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         evt_mask_r <= IPC_RST_VAL[3:0];
      end else if (wr_evt_mask) begin
         evt_mask_r <= reg_req_i.wdata[3:0] & IPC_VALID_EVT;
      end
   end

   assign irq_o = |(evt_stat_r & evt_mask_r);

   // ----------------------------------------------------------------
   // read data, one cycle after the read strobe, zero otherwise
   // ----------------------------------------------------------------
   logic [7:0] rd_mux;

   always_comb begin
      rd_mux = 8'h00;
      if (reg_req_i.addr == IPC_OFS_FLAGS_B) begin
         rd_mux = flags_b; // [R3]
      end else if (reg_req_i.addr == IPC_OFS_FLAGS_C) begin
         rd_mux = flags_c; // [R3]
      end else if (reg_req_i.addr == IPC_OFS_SOFT_CTRL) begin
         rd_mux = soft_ctrl_r;
      end else if (reg_req_i.addr == IPC_OFS_MASK_C) begin
         rd_mux = mask_c_r;
      end else if (reg_req_i.addr == IPC_OFS_MASK_A) begin
         rd_mux = mask_a_r;
      end else if (reg_req_i.addr == IPC_OFS_MASK_B) begin
         rd_mux = mask_b_r;
      end else if (reg_req_i.addr == IPC_OFS_EVT_STAT) begin
         rd_mux = {4'h0, evt_stat_r};
      end else if (reg_req_i.addr == IPC_OFS_EVT_MASK) begin
         rd_mux = {4'h0, evt_mask_r};
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         reg_rdata_o <= IPC_RST_VAL;
      end else if (reg_req_i.rd) begin
         reg_rdata_o <= rd_mux;
      end else begin
         reg_rdata_o <= 8'h00;
      end
   end

endmodule
`default_nettype wire

/* File: include/ipc_pkg.sv */
// constants and types for the interrupt post, clear and mask register block
//
// Overview of operation
// [R1] flags b: timer, 1ms, usb, endpoint bits
// [R2] flags c: gpio port2, line two, wrap
// [R3] flag read returns posted state per source
// [R4] soft-post off: writing 0 clears flag
// [R5] soft-post off: writing 1 changes nothing
// [R6] soft-post on: writing 0 is ignored
// [R7] soft-post on: writing 1 posts request
// [R8] pending only while mask bit is set
// [R9] events post even when masked
// [R10] each mask bit gates only its source
// [R11] soft-post enable is bit 7, rest reserved
// [R12] mask c: gpio2, line two, wrap bits
// [R13] three separate mask registers cover all sources
// [R14] flag holds until taken or cleared
// [R15] pending go to encoder, taken under global enable
// [R16] event beats a same-cycle clear
package ipc_pkg;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] IPC_OFS_FLAGS_B = 8'hdb;
   localparam logic [7:0] IPC_OFS_FLAGS_C = 8'hdc;
   localparam logic [7:0] IPC_OFS_SOFT_CTRL = 8'hde;
   localparam logic [7:0] IPC_OFS_MASK_C = 8'hdf;
   localparam logic [7:0] IPC_OFS_MASK_A = 8'he0;
   localparam logic [7:0] IPC_OFS_MASK_B = 8'he1;
   localparam logic [7:0] IPC_OFS_EVT_STAT = 8'he2;
   localparam logic [7:0] IPC_OFS_EVT_MASK = 8'he3;

   // ----------------------------------------------------------------
   // reset values and implemented-bit masks
   // ----------------------------------------------------------------
   localparam logic [7:0] IPC_RST_VAL = 8'h00;
   localparam logic [7:0] IPC_VALID_B = 8'h7f;
   localparam logic [7:0] IPC_VALID_C = 8'h16;
   localparam logic [7:0] IPC_VALID_A = 8'hff;
   localparam logic [7:0] IPC_VALID_SOFT = 8'h80;
   localparam logic [3:0] IPC_VALID_EVT = 4'hf;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int IPC_SOFT_EN_BIT = 7;
   localparam int IPC_B_EP0 = 0;
   localparam int IPC_B_EP1 = 1;
   localparam int IPC_B_EP2 = 2;
   localparam int IPC_B_USB_RST = 3;
   localparam int IPC_B_USB_ACT = 4;
   localparam int IPC_B_TMR_1MS = 5;
   localparam int IPC_B_PIT = 6;
   localparam int IPC_C_WRAP = 1;
   localparam int IPC_C_EXT_LINE_TWO = 2;
   localparam int IPC_C_GPIO2 = 4;

   // block event status bits
   localparam int IPC_EV_SW_POST = 0;
   localparam int IPC_EV_SW_CLEAR = 1;
   localparam int IPC_EV_MASKED_POST = 2;
   localparam int IPC_EV_TAKEN = 3;

   // priority number of flags b bit 0; flags c bit n follows at base + 8 + n
   localparam logic [4:0] IPC_PRIO_BASE = 5'h08;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } ipc_bus_req_t;

   typedef struct packed {
      logic valid;
      logic [4:0] prio;
   } ipc_irq_req_t;

endpackage

/* File: verilog/ipc_flag_bank.sv */
// one posted-flag register: hardware posting, software clear and software post
`timescale 1ns/1ps
`default_nettype none
module ipc_flag_bank
   import ipc_pkg::*;
#(
   parameter logic [7:0] VALID = 8'hff
) (
   input wire logic sys_clk_i,
   input wire logic srst_i,
   input wire logic [7:0] hw_set_i,
   input wire logic wr_i,
   input wire logic [7:0] wdata_i,
   input wire logic soft_en_i,
   input wire logic [7:0] take_clr_i,
   output logic [7:0] flags_o,
   output logic [7:0] flags_nxt_o
);

   logic [7:0] flags_r;
   logic [7:0] set_w;
   logic [7:0] clr_w;

   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_bit
         // events post regardless of mask; a written 1 posts only with soft-post on
         assign set_w[g] = VALID[g] & (hw_set_i[g] | (wr_i & soft_en_i & wdata_i[g])); // [R7] [R9]
         // a written 0 clears only with soft-post off; 1s then do nothing
         assign clr_w[g] = (wr_i & ~soft_en_i & ~wdata_i[g]) | take_clr_i[g]; // [R4] [R5] [R6]
         // set wins over any clear in the same cycle
         assign flags_nxt_o[g] = set_w[g] | (flags_r[g] & ~clr_w[g]); // [R16] [R14]
      end
   endgenerate

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         flags_r <= IPC_RST_VAL;
      end else begin
         flags_r <= flags_nxt_o;
      end
   end

   assign flags_o = flags_r;

endmodule
`default_nettype wire

/* File: verilog/ipc_prio_enc.sv */
// priority encoder over the pending requests; lowest index wins
`timescale 1ns/1ps
`default_nettype none
module ipc_prio_enc
   import ipc_pkg::*;
(
   input wire logic [15:0] pending_i,
   output logic found_o,
   output logic [3:0] index_o
);

   function automatic logic [4:0] first_set(input logic [15:0] v);
      logic [4:0] r;
      r = 5'h00;
      for (int i = 15; i >= 0; i--) begin
         if (v[i]) begin
            r = {1'b1, 4'(i)};
         end
      end
      return r;
   endfunction

   always_comb begin
      {found_o, index_o} = first_set(pending_i); // [R15]
   end

endmodule
`default_nettype wire

/* File: tb/ipc_irq_regs_assertions.sv */
// port checker for the interrupt post, clear and mask register block
`timescale 1ns/1ps
`default_nettype none
module ipc_irq_regs_assertions
   import ipc_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic srst_i,
   input wire ipc_bus_req_t reg_req_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic [7:0] hw_evt_b_i,
   input wire logic [7:0] hw_evt_c_i,
   input wire logic [7:0] posted_flags_a_i,
   input wire logic [7:0] pending_a_o,
   input wire logic global_irq_enable_i,
   input wire logic take_i,
   input wire ipc_irq_req_t irq_req_o,
   input wire logic irq_o
);
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (srst_i);
   // ----
   // sequences
   // ----
   sequence s_rd(logic [7:0] a);
      reg_req_i.rd && reg_req_i.addr == a;
   endsequence
   sequence s_take;
      take_i && irq_req_o.valid && hw_evt_b_i == 8'h00 && hw_evt_c_i == 8'h00 && !reg_req_i.wr;
   endsequence
   // ----
   // assertions
   // ----
   pend_a_gate_a: assert property ((pending_a_o & ~posted_flags_a_i) == 8'h00)
      else $error("pending bit without posted flag");
   rdata_idle_a: assert property (!reg_req_i.rd |=> reg_rdata_o == 8'h00)
      else $error("read data outside read answer cycle");
   flags_b_rsv_a: assert property (s_rd(IPC_OFS_FLAGS_B) |=> !reg_rdata_o[7])
      else $error("flags b reserved bit reads one");
   flags_c_rsv_a: assert property (s_rd(IPC_OFS_FLAGS_C) |=> (reg_rdata_o & 8'he9) == 8'h00)
      else $error("flags c reserved bit reads one");
   soft_rsv_a: assert property (s_rd(IPC_OFS_SOFT_CTRL) |=> reg_rdata_o[6:0] == 7'h00)
      else $error("soft control reserved bit reads one");
   mask_c_rsv_a: assert property (s_rd(IPC_OFS_MASK_C) |=> (reg_rdata_o & 8'he9) == 8'h00)
      else $error("mask c reserved bit reads one");
   glob_en_block_a: assert property (!global_irq_enable_i [*3] |-> !irq_req_o.valid)
      else $error("request shown without global enable");
   prio_range_a: assert property (irq_req_o.valid |->
      irq_req_o.prio inside {[5'd8:5'd14], 5'd17, 5'd18, 5'd20})
      else $error("request priority outside source set");
   take_clear_a: assert property (s_take |=>
      !(irq_req_o.valid && irq_req_o.prio == $past(irq_req_o.prio)))
      else $error("taken request still shown");
   irq_mask_a: assert property (reg_req_i.wr && reg_req_i.addr == IPC_OFS_EVT_MASK &&
      reg_req_i.wdata[3:0] == 4'h0 |=> !irq_o)
      else $error("interrupt high with all events masked");
endmodule
bind ipc_irq_regs ipc_irq_regs_assertions u_chk (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
   .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o), .hw_evt_b_i(hw_evt_b_i),
   .hw_evt_c_i(hw_evt_c_i), .posted_flags_a_i(posted_flags_a_i), .pending_a_o(pending_a_o),
   .global_irq_enable_i(global_irq_enable_i), .take_i(take_i), .irq_req_o(irq_req_o),
   .irq_o(irq_o));
`default_nettype wire

/* File: tb/ipc_irq_regs_tb_top.sv */
// self-checking bench for the interrupt post, clear and mask register block
`timescale 1ns/1ps
`default_nettype none
module ipc_irq_regs_tb_top
   import ipc_pkg::*;
;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   ipc_bus_req_t req = '0;
   logic [7:0] evb = 8'h00;
   logic [7:0] evc = 8'h00;
   logic [7:0] pfa = 8'h00;
   logic glob_en = 1'b0;
   logic take = 1'b0;
   logic [7:0] rdata;
   logic [7:0] pend_a;
   ipc_irq_req_t irq_req;
   logic irq;
   logic [15:0] lfsr = 16'he842;
   logic [7:0] ofs [8] = '{8'hdb, 8'hdc, 8'hde, 8'hdf, 8'he0, 8'he1, 8'he2, 8'he3};
   int mismatches = 0;
   int samples_checked = 0;
   int fb = 0, fc = 0, ma = 0, mb = 0, mc = 0, sc = 0, p = 0;

   always #5 sys_clk = ~sys_clk;

   ipc_irq_regs u_dut (.sys_clk_i(sys_clk), .srst_i(srst), .reg_req_i(req), .reg_rdata_o(rdata),
      .hw_evt_b_i(evb), .hw_evt_c_i(evc), .posted_flags_a_i(pfa), .pending_a_o(pend_a),
      .global_irq_enable_i(glob_en), .take_i(take), .irq_req_o(irq_req), .irq_o(irq));

   // ----
   // model and helpers
   // ----
   function logic [7:0] rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr[7:0];
   endfunction
   function logic [7:0] mdl(input logic [7:0] a);
      case (a)
         8'hdb: return fb[7:0];
         8'hdc: return fc[7:0];
         8'hde: return sc[7:0];
         8'hdf: return mc[7:0];
         8'he0: return ma[7:0];
         8'he1: return mb[7:0];
         default: return 8'h00;
      endcase
   endfunction
   function logic [5:0] req_exp();
      for (int i = 0; i < 8; i++) begin
         if (fb[i] && mb[i] && glob_en) return {1'b1, 5'(8 + i)};
      end
      for (int i = 0; i < 8; i++) begin
         if (fc[i] && mc[i] && glob_en) return {1'b1, 5'(16 + i)};
      end
      return 6'h00;
   endfunction
   task chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      req.addr <= a;
      req.wdata <= d;
      req.wr <= 1'b1;
      @(posedge sys_clk);
      req.wr <= 1'b0;
      case (a)
         8'hdb: fb = sc[7] ? fb | (d & IPC_VALID_B) : fb & d;
         8'hdc: fc = sc[7] ? fc | (d & IPC_VALID_C) : fc & d;
         8'hde: sc = d & IPC_VALID_SOFT;
         8'hdf: mc = d & IPC_VALID_C;
         8'he0: ma = d;
         8'he1: mb = d & IPC_VALID_B;
         default: ;
      endcase
   endtask
   task rd_exp(input logic [7:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      req.addr <= a;
      req.rd <= 1'b1;
      @(posedge sys_clk);
      req.rd <= 1'b0;
      #1 chk8($sformatf("reg_%h", a), e, rdata);
   endtask
   task ev(input logic [7:0] b, input logic [7:0] c);
      @(posedge sys_clk);
      evb <= b;
      evc <= c;
      @(posedge sys_clk);
      evb <= 8'h00;
      evc <= 8'h00;
      fb = fb | (b & IPC_VALID_B);
      fc = fc | (c & IPC_VALID_C);
   endtask
   // the priority number carries meaning only while the request is valid
   task chk_req();
      logic [5:0] e;
      #1 e = req_exp();
      chk8("irq_req_o.valid", {7'h00, e[5]}, {7'h00, irq_req.valid});
      if (e[5]) begin
         chk8("irq_req_o.prio", {3'b000, e[4:0]}, {3'b000, irq_req.prio});
      end
   endtask
   task give_verdict();
      if (mismatches == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge sys_clk);
      mismatches++;
      give_verdict();
   end

   // ----
   // scenarios
   // ----
   initial begin
      repeat (2) @(posedge sys_clk);
      srst <= 1'b0;
      foreach (ofs[i]) rd_exp(ofs[i], 8'h00);
      for (int i = 2; i < 6; i++) wr(ofs[i], 8'hff);
      for (int i = 2; i < 6; i++) rd_exp(ofs[i], mdl(ofs[i]));
      wr(8'h10, 8'hff);
      rd_exp(8'h10, 8'h00);
      wr(8'hde, 8'h00);
      for (int i = 0; i < 8; i++) begin
         wr(8'he0, rnd());
         pfa <= rnd();
         #1 chk8("pending_a_o", pfa & ma[7:0], pend_a);
      end
      wr(8'hde, 8'h80);
      wr(8'hdb, rnd());
      wr(8'hdc, rnd());
      wr(8'hdb, 8'h00);
      for (int i = 0; i < 2; i++) rd_exp(ofs[i], mdl(ofs[i]));
      wr(8'hde, 8'h00);
      wr(8'hdb, rnd());
      wr(8'hdc, rnd());
      for (int i = 0; i < 2; i++) rd_exp(ofs[i], mdl(ofs[i]));
      wr(8'he1, 8'h00);
      wr(8'hdf, 8'h00);
      ev(8'hff, 8'hff);
      for (int i = 0; i < 2; i++) rd_exp(ofs[i], mdl(ofs[i]));
      wr(8'hdc, 8'h00);
      ev(8'h00, 8'h16);
      @(posedge sys_clk);
      req.addr <= 8'hdc;
      req.wdata <= 8'h00;
      req.wr <= 1'b1;
      evc <= 8'h04;
      @(posedge sys_clk);
      req.wr <= 1'b0;
      evc <= 8'h00;
      fc = 8'h04;
      rd_exp(8'hdc, mdl(8'hdc));
      wr(8'hdb, 8'h00);
      wr(8'hdc, 8'h00);
      wr(8'he1, 8'h08);
      wr(8'hdf, 8'h02);
      glob_en <= 1'b1;
      ev(8'h08, 8'h02);
      repeat (2) @(posedge sys_clk);
      chk_req();
      @(posedge sys_clk);
      glob_en <= 1'b0;
      repeat (3) @(posedge sys_clk);
      chk_req();
      @(posedge sys_clk);
      glob_en <= 1'b1;
      repeat (3) @(posedge sys_clk);
      chk_req();
      for (int i = 0; i < 2; i++) begin
         p = req_exp() & 6'h1f;
         @(posedge sys_clk);
         take <= 1'b1;
         @(posedge sys_clk);
         take <= 1'b0;
         if (p < 16) fb = fb & ~(1 << (p - 8));
         else fc = fc & ~(1 << (p - 16));
         chk_req();
      end
      for (int i = 0; i < 2; i++) rd_exp(ofs[i], mdl(ofs[i]));
      wr(8'he3, 8'h0f);
      wr(8'he2, 8'h0f);
      #1 chk8("irq_o", 8'h00, {7'h00, irq});
      wr(8'hdb, 8'h00);
      #1 chk8("irq_o", 8'h01, {7'h00, irq});
      rd_exp(8'he2, 8'h02);
      wr(8'he3, 8'h00);
      #1 chk8("irq_o", 8'h00, {7'h00, irq});
      wr(8'he3, 8'h0f);
      wr(8'he2, 8'h02);
      #1 chk8("irq_o", 8'h00, {7'h00, irq});
      give_verdict();
   end
endmodule
`default_nettype wire
